/* File: hw/io_space_pkg.sv */
// constants for the i/o register space decoder
package io_space_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IO_ADDR_W = 6;
  localparam int unsigned DS_ADDR_W = 8;
  // direct i/o window and offsets into data space
  localparam logic [7:0] IO_LAST = 8'h3f;
  localparam logic [7:0] BIT_LAST = 8'h1f;
  localparam logic [7:0] DS_IO_OFFSET = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hff;
  // register offsets (direct i/o addresses)
  localparam logic [5:0] OFF_PB_IN = 6'h03;
  localparam logic [5:0] OFF_PB_DIR = 6'h04;
  localparam logic [5:0] OFF_PB_OUT = 6'h05;
  localparam logic [5:0] OFF_PC_IN = 6'h06;
  localparam logic [5:0] OFF_PC_DIR = 6'h07;
  localparam logic [5:0] OFF_PC_OUT = 6'h08;
  localparam logic [5:0] OFF_PD_IN = 6'h09;
  localparam logic [5:0] OFF_PD_DIR = 6'h0a;
  localparam logic [5:0] OFF_PD_OUT = 6'h0b;
  localparam logic [5:0] OFF_T0_FLAGS = 6'h15;
  localparam logic [5:0] OFF_T1_FLAGS = 6'h16;
  localparam logic [5:0] OFF_T2_FLAGS = 6'h17;
  localparam logic [5:0] OFF_PCH_FLAGS = 6'h1b;
  localparam logic [5:0] OFF_GP_STORE0 = 6'h1e;
  localparam logic [5:0] OFF_EE_CTRL = 6'h1f;
  // implemented-bit masks; other bits are reserved
  localparam logic [7:0] MASK_PC = 8'h7f;
  localparam logic [7:0] MASK_T0 = 8'h07;
  localparam logic [7:0] MASK_T1 = 8'h27;
  localparam logic [7:0] MASK_T2 = 8'h07;
  localparam logic [7:0] MASK_PCH = 8'h07;
  localparam logic [7:0] MASK_EE = 8'h07;
  localparam logic [7:0] RST_VAL = 8'h00;
  // access kinds from the core
  typedef enum logic [2:0] {
    ACC_NONE = 3'h0,
    ACC_IO_READ = 3'h1,
    ACC_IO_WRITE = 3'h2,
    ACC_DS_READ = 3'h3,
    ACC_DS_WRITE = 3'h4,
    ACC_BIT_SET = 3'h5,
    ACC_BIT_CLR = 3'h6,
    ACC_BIT_TEST = 3'h7
  } acc_kind_t;
endpackage : io_space_pkg

/* File: hw/io_register_space_decoder.sv */
// i/o register space decoder with bit access and write-one-to-clear flags
// Behaviour
// - set and clear of single bits only at i/o addresses 0x00 to 0x1f
// - bit tests return one selected bit of a bit-accessible register
// - status flags clear on a written one; a written zero leaves them
// - set or clear touches only the addressed bit, never other flags
// - direct i/o access uses six-bit addresses 0 to 63
// - data-space address equals i/o address plus 0x20, same register
// - extended range 0x60 to 0xff reachable by load and store only
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decoder
  import io_space_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // core access port
  input wire logic [2:0] acc_kind,
  input wire logic [DS_ADDR_W-1:0] acc_addr,
  input wire logic [2:0] acc_bit,
  input wire logic [DATA_W-1:0] acc_wdata,
  output logic [DATA_W-1:0] acc_rdata,
  output logic acc_bit_value,
  output logic acc_hit,
  // extended i/o space, handled outside
  output logic ext_sel,
  output logic ext_write,
  output logic [DS_ADDR_W-1:0] ext_addr,
  output logic [DATA_W-1:0] ext_wdata,
  input wire logic [DATA_W-1:0] ext_rdata,
  // port pins and drive
  input wire logic [DATA_W-1:0] port_b_pins,
  input wire logic [DATA_W-1:0] port_c_pins,
  input wire logic [DATA_W-1:0] port_d_pins,
  output logic [DATA_W-1:0] port_b_dir,
  output logic [DATA_W-1:0] port_b_out,
  output logic [DATA_W-1:0] port_c_dir,
  output logic [DATA_W-1:0] port_c_out,
  output logic [DATA_W-1:0] port_d_dir,
  output logic [DATA_W-1:0] port_d_out,
  output logic [DATA_W-1:0] ee_ctrl,
  // flag set events from peripherals
  input wire logic [DATA_W-1:0] t0_flag_set,
  input wire logic [DATA_W-1:0] t1_flag_set,
  input wire logic [DATA_W-1:0] t2_flag_set,
  input wire logic [DATA_W-1:0] pch_flag_set,
  output logic [DATA_W-1:0] t0_flags,
  output logic [DATA_W-1:0] t1_flags,
  output logic [DATA_W-1:0] t2_flags,
  output logic [DATA_W-1:0] pch_flags
);

  typedef struct packed {
    logic [7:0] pb_dir;
    logic [7:0] pb_out;
    logic [7:0] pc_dir;
    logic [7:0] pc_out;
    logic [7:0] pd_dir;
    logic [7:0] pd_out;
    logic [7:0] t0;
    logic [7:0] t1;
    logic [7:0] t2;
    logic [7:0] pch;
    logic [7:0] gp0;
    logic [7:0] ee;
    logic [7:0] rdata;
    logic bitval;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  acc_kind_t kind;
  logic [7:0] io_addr;
  logic io_ok;
  logic is_rd;
  logic is_wr;
  logic is_bit;
  logic [5:0] ra;
  logic [7:0] cur;
  logic [7:0] bit_mask;
  logic [7:0] wr_val;
  logic [7:0] clr_w1;
  logic ext_ok;

  assign kind = acc_kind_t'(acc_kind);

  // address translation: direct i/o keeps 6 bits, data space drops the offset
  always_comb
  begin
    io_addr = 8'h00;
    io_ok = 1'b0;
    ext_ok = 1'b0;
    is_rd = 1'b0;
    is_wr = 1'b0;
    is_bit = 1'b0;
    unique case (kind)
      ACC_IO_READ, ACC_IO_WRITE:
      begin
        io_addr = {2'b00, acc_addr[IO_ADDR_W-1:0]};
        io_ok = (acc_addr <= IO_LAST);
        is_rd = (kind == ACC_IO_READ);
        is_wr = (kind == ACC_IO_WRITE);
      end
      ACC_DS_READ, ACC_DS_WRITE:
      begin
        io_addr = 8'(acc_addr - DS_IO_OFFSET);
        io_ok = (acc_addr >= DS_IO_OFFSET) && (acc_addr < EXT_FIRST);
        ext_ok = (acc_addr >= EXT_FIRST) && (acc_addr <= EXT_LAST);
        is_rd = (kind == ACC_DS_READ);
        is_wr = (kind == ACC_DS_WRITE);
      end
      ACC_BIT_SET, ACC_BIT_CLR, ACC_BIT_TEST:
      begin
        io_addr = acc_addr;
        io_ok = (acc_addr <= BIT_LAST);
        is_bit = 1'b1;
      end
      default:
      begin
        io_addr = 8'h00;
      end
    endcase
  end

  assign ra = io_addr[5:0];
  assign bit_mask = 8'h01 << acc_bit;

  // current register value; reserved addresses and bits read zero
  always_comb
  begin
    unique case (ra)
      OFF_PB_IN: cur = port_b_pins;
      OFF_PB_DIR: cur = st_r.pb_dir;
      OFF_PB_OUT: cur = st_r.pb_out;
      OFF_PC_IN: cur = port_c_pins & MASK_PC;
      OFF_PC_DIR: cur = st_r.pc_dir;
      OFF_PC_OUT: cur = st_r.pc_out;
      OFF_PD_IN: cur = port_d_pins;
      OFF_PD_DIR: cur = st_r.pd_dir;
      OFF_PD_OUT: cur = st_r.pd_out;
      OFF_T0_FLAGS: cur = st_r.t0;
      OFF_T1_FLAGS: cur = st_r.t1;
      OFF_T2_FLAGS: cur = st_r.t2;
      OFF_PCH_FLAGS: cur = st_r.pch;
      OFF_GP_STORE0: cur = st_r.gp0;
      OFF_EE_CTRL: cur = st_r.ee;
      default: cur = RST_VAL;
    endcase
  end

  // value written and the one-bits that clear flags
  always_comb
  begin
    wr_val = acc_wdata;
    clr_w1 = acc_wdata;
    if (is_bit)
    begin
      // only the addressed bit is touched; no other flag sees a one
      wr_val = (kind == ACC_BIT_SET) ? (cur | bit_mask) : (cur & ~bit_mask);
      clr_w1 = (kind == ACC_BIT_SET) ? bit_mask : 8'h00;
    end
  end

  // next state: register writes, flag set and clear, read data
  always_comb
  begin
    logic wr;
    wr = io_ok && (is_wr || (is_bit && kind != ACC_BIT_TEST));
    st_nxt = st_r;
    if (wr)
    begin
      unique case (ra)
        OFF_PB_DIR: st_nxt.pb_dir = wr_val;
        OFF_PB_OUT: st_nxt.pb_out = wr_val;
        OFF_PC_DIR: st_nxt.pc_dir = wr_val & MASK_PC;
        OFF_PC_OUT: st_nxt.pc_out = wr_val & MASK_PC;
        OFF_PD_DIR: st_nxt.pd_dir = wr_val;
        OFF_PD_OUT: st_nxt.pd_out = wr_val;
        OFF_T0_FLAGS: st_nxt.t0 = st_r.t0 & ~clr_w1;
        OFF_T1_FLAGS: st_nxt.t1 = st_r.t1 & ~clr_w1;
        OFF_T2_FLAGS: st_nxt.t2 = st_r.t2 & ~clr_w1;
        OFF_PCH_FLAGS: st_nxt.pch = st_r.pch & ~clr_w1;
        OFF_GP_STORE0: st_nxt.gp0 = wr_val;
        OFF_EE_CTRL: st_nxt.ee = wr_val & MASK_EE;
        default: st_nxt.gp0 = st_r.gp0;
      endcase
    end
    // set wins over a clear in the same cycle
    st_nxt.t0 = (st_nxt.t0 | t0_flag_set) & MASK_T0;
    st_nxt.t1 = (st_nxt.t1 | t1_flag_set) & MASK_T1;
    st_nxt.t2 = (st_nxt.t2 | t2_flag_set) & MASK_T2;
    st_nxt.pch = (st_nxt.pch | pch_flag_set) & MASK_PCH;
    if (is_rd)
      st_nxt.rdata = io_ok ? cur : (ext_ok ? ext_rdata : RST_VAL);
    if (kind == ACC_BIT_TEST)
      st_nxt.bitval = io_ok ? cur[acc_bit] : 1'b0;
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // outputs
  assign acc_rdata = st_r.rdata;
  assign acc_bit_value = st_r.bitval;
  assign acc_hit = io_ok || ext_ok;
  assign ext_sel = ext_ok;
  assign ext_write = ext_ok && is_wr;
  assign ext_addr = acc_addr;
  assign ext_wdata = acc_wdata;
  assign port_b_dir = st_r.pb_dir;
  assign port_b_out = st_r.pb_out;
  assign port_c_dir = st_r.pc_dir;
  assign port_c_out = st_r.pc_out;
  assign port_d_dir = st_r.pd_dir;
  assign port_d_out = st_r.pd_out;
  assign ee_ctrl = st_r.ee;
  assign t0_flags = st_r.t0;
  assign t1_flags = st_r.t1;
  assign t2_flags = st_r.t2;
  assign pch_flags = st_r.pch;

  // checks; a flag pulse can move state in any cycle, so refusal checks want it quiet
  logic any_set;
  assign any_set = |{t0_flag_set, t1_flag_set, t2_flag_set, pch_flag_set};

  // bit access window and bit tests
  a_bit_range_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_BIT_SET && acc_addr > BIT_LAST && !any_set) |=> $stable(st_r))
    else $error("bit set above bit range changed state");
  a_bit_clr_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_BIT_CLR && acc_addr > BIT_LAST && !any_set) |=> $stable(st_r))
    else $error("bit clear above bit range changed state");
  a_bit_test_value: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_BIT_TEST && acc_addr == {2'b00, OFF_GP_STORE0}) |=>
    acc_bit_value == $past(st_r.gp0[acc_bit]))
    else $error("bit test value wrong");
  a_bit_test_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_BIT_TEST && acc_addr > BIT_LAST) |=> !acc_bit_value)
    else $error("bit test above bit range returned one");

  // write-one-to-clear flags
  a_w1c_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_IO_WRITE && acc_addr == {2'b00, OFF_T0_FLAGS} && acc_wdata[0]
    && !t0_flag_set[0]) |=> !t0_flags[0])
    else $error("flag not cleared by a one");
  a_w1c_zero_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_IO_WRITE && acc_addr == {2'b00, OFF_T1_FLAGS} && acc_wdata == 8'h00
    && t1_flag_set == 8'h00) |=> t1_flags == $past(t1_flags))
    else $error("written zero changed flags");
  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    t0_flag_set[0] |=> t0_flags[0])
    else $error("flag set lost against a clear");

  // single-bit ops on flag registers
  a_bit_set_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_BIT_SET && acc_addr == {2'b00, OFF_T2_FLAGS} && acc_bit != 3'h0
    && t2_flags[0]) |=> t2_flags[0])
    else $error("bit set cleared another flag");
  a_bit_clr_keeps: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_BIT_CLR && acc_addr == {2'b00, OFF_T1_FLAGS} && t1_flags[5]) |=>
    t1_flags[5])
    else $error("bit clear cleared a flag");

  // direct i/o window and its data-space alias
  a_io_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_IO_WRITE && acc_addr == {2'b00, OFF_PD_DIR}) |=>
    port_d_dir == $past(acc_wdata))
    else $error("direct i/o write missed register");
  a_io_high_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_IO_WRITE && acc_addr > IO_LAST && !any_set) |=> $stable(st_r))
    else $error("i/o write above 0x3f changed state");
  a_io_ds_same: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_DS_WRITE && acc_addr == (DS_IO_OFFSET + {2'b00, OFF_GP_STORE0})) |=>
    st_r.gp0 == $past(acc_wdata))
    else $error("data-space alias missed register");
  a_ds_read_alias: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_DS_READ && acc_addr == (DS_IO_OFFSET + {2'b00, OFF_PB_DIR})) |=>
    acc_rdata == $past(port_b_dir))
    else $error("data-space read missed register");

  // extended range and reserved places
  a_io_no_ext: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_IO_READ || kind == ACC_IO_WRITE) |-> !ext_sel)
    else $error("direct i/o reached extended space");
  a_ext_only_ds: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_sel |-> (kind == ACC_DS_READ || kind == ACC_DS_WRITE) && acc_addr >= EXT_FIRST)
    else $error("extended select outside load and store");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (kind == ACC_IO_READ && acc_addr == 8'h10) |=> acc_rdata == 8'h00)
    else $error("reserved address read nonzero");
  a_rsv_bits_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    !port_c_dir[7] && !port_c_out[7] && ee_ctrl[7:3] == 5'h00)
    else $error("reserved register bit set");

endmodule : io_register_space_decoder
`default_nettype wire

/* File: bench/core_access_model.sv */
// core-side model that issues i/o and load/store accesses
`timescale 1ns/1ps
`default_nettype none
module core_access_model
  import io_space_pkg::*;
(
  // clock
  input wire logic core_clk,
  // access request
  output logic [2:0] acc_kind,
  output logic [DS_ADDR_W-1:0] acc_addr,
  output logic [2:0] acc_bit,
  output logic [DATA_W-1:0] acc_wdata
);
  // idle at time zero
  initial
  begin
    acc_kind = 3'h0;
    acc_addr = 8'h00;
    acc_bit = 3'h0;
    acc_wdata = 8'h00;
  end
  // one access held across one rising edge; callers also write reserved bits and reserved places
  task automatic op(input acc_kind_t k, input logic [7:0] a, input logic [2:0] b,
    input logic [7:0] d);
    @(negedge core_clk);
    acc_kind = k;
    acc_addr = a;
    acc_bit = b;
    acc_wdata = d;
    @(negedge core_clk);
    acc_kind = 3'h0;
    acc_wdata = ~d; // released data does not keep its value
  endtask : op
endmodule : core_access_model
`default_nettype wire

/* File: bench/tb_io_register_space_decoder.sv */
// self-checking bench for the i/o register space decoder
`timescale 1ns/1ps
`default_nettype none
module tb_io_register_space_decoder import io_space_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] acc_kind, acc_bit;
  logic [7:0] acc_addr, acc_wdata, acc_rdata, ext_addr, ext_wdata, ext_rdata, ee_ctrl;
  logic acc_bit_value, acc_hit, ext_sel, ext_write;
  logic [7:0] port_b_pins, port_c_pins, port_d_pins, port_b_dir, port_b_out, port_c_dir;
  logic [7:0] port_c_out, port_d_dir, port_d_out, t0_flags, t1_flags, t2_flags, pch_flags;
  logic [7:0] t0_flag_set, t1_flag_set, t2_flag_set, pch_flag_set;
  logic [31:0] lfsr = 32'h0576;
  int n_fail = 0;
  int compares = 0;
  int m[64];
  int rw[8] = '{4, 5, 7, 8, 10, 11, 30, 31};
  int fl[4] = '{21, 22, 23, 27};
  // device and core model
  io_register_space_decoder dut (.core_clk, .rst_n, .acc_kind, .acc_addr, .acc_bit,
    .acc_wdata, .acc_rdata, .acc_bit_value, .acc_hit, .ext_sel, .ext_write, .ext_addr,
    .ext_wdata, .ext_rdata, .port_b_pins, .port_c_pins, .port_d_pins, .port_b_dir,
    .port_b_out, .port_c_dir, .port_c_out, .port_d_dir, .port_d_out, .ee_ctrl,
    .t0_flag_set, .t1_flag_set, .t2_flag_set, .pch_flag_set, .t0_flags, .t1_flags,
    .t2_flags, .pch_flags);
  core_access_model core (.core_clk, .acc_kind, .acc_addr, .acc_bit, .acc_wdata);
  // clock
  always #10 core_clk = ~core_clk;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  // implemented bits per i/o address
  function automatic int msk(input int a);
    case (a)
      4, 5, 10, 11, 30: return 8'hff;
      7, 8: return MASK_PC;
      21, 23: return MASK_T0;
      22: return MASK_T1;
      27: return MASK_PCH;
      31: return MASK_EE;
      default: return 0;
    endcase
  endfunction : msk
  function automatic logic [7:0] exp_rd(input int a);
    case (a)
      3: return port_b_pins;
      6: return port_c_pins & MASK_PC;
      9: return port_d_pins;
      default: return 8'(m[a] & msk(a));
    endcase
  endfunction : exp_rd
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input acc_kind_t k, input int a, input logic [7:0] d);
    int i;
    i = (k == ACC_DS_WRITE) ? a - 32 : a;
    core.op(k, 8'(a), 3'h0, d);
    m[i] = (i inside {fl}) ? m[i] & ~int'(d) : int'(d);
  endtask : wr
  task automatic rd(input acc_kind_t k, input int a);
    int i;
    i = (k == ACC_DS_READ) ? a - 32 : a;
    core.op(k, 8'(a), 3'h0, 8'h00);
    chk("read data", exp_rd(i), acc_rdata);
  endtask : rd
  task automatic bop(input acc_kind_t k, input int a, input int b);
    core.op(k, 8'(a), 3'(b), 8'h00);
    if (k == ACC_BIT_SET && a < 32)
      m[a] = (a inside {fl}) ? m[a] & ~(1 << b) : m[a] | (1 << b);
    else if (k == ACC_BIT_CLR && a < 32 && !(a inside {fl}))
      m[a] = m[a] & ~(1 << b);
    else if (k == ACC_BIT_TEST)
      chk("bit value", 8'((exp_rd(a) >> b) & 1), {7'h0, acc_bit_value});
  endtask : bop
  // one-cycle set pulse on every flag input
  task automatic pulse();
    @(negedge core_clk);
    {t0_flag_set, t1_flag_set, t2_flag_set, pch_flag_set} = 32'hffffffff;
    @(negedge core_clk);
    {t0_flag_set, t1_flag_set, t2_flag_set, pch_flag_set} = 32'h0;
    foreach (fl[j]) m[fl[j]] = 8'hff;
  endtask : pulse
  // extended-range access seen on the pass-through side
  task automatic xop(input acc_kind_t k, input logic [7:0] a, input logic sel);
    fork
      core.op(k, a, 3'h0, 8'h5a);
      begin
        @(negedge core_clk);
        #1;
        chk("ext select", {7'h0, sel}, {7'h0, ext_sel});
        chk("hit", {7'h0, sel}, {7'h0, acc_hit});
        chk("ext write", {7'h0, sel && k == ACC_DS_WRITE}, {7'h0, ext_write});
        if (sel) chk("ext address", a, ext_addr);
        if (sel) chk("ext write data", 8'h5a, ext_wdata);
      end
    join
  endtask : xop
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // main sequence
  initial
  begin
    {port_b_pins, port_c_pins, port_d_pins, ext_rdata} = {rnd(), rnd(), rnd(), rnd()};
    {t0_flag_set, t1_flag_set, t2_flag_set, pch_flag_set} = 32'h0;
    foreach (m[i]) m[i] = 0;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    for (int a = 0; a < 64; a++) rd(ACC_IO_READ, a);
    // port c writes carry its reserved top bit, except the data-space write to port c dir
    foreach (rw[j])
    begin
      wr(ACC_IO_WRITE, rw[j], rnd());
      rd(ACC_DS_READ, rw[j] + 32);
      wr(ACC_DS_WRITE, rw[j] + 32, rnd());
      rd(ACC_IO_READ, rw[j]);
    end
    // refused accesses outside the bit and i/o windows, then the port outputs except port d dir, and the eeprom control
    bop(ACC_BIT_CLR, 8'h25, 0);
    bop(ACC_BIT_TEST, 8'h25, 0);
    core.op(ACC_IO_WRITE, 8'h5e, 3'h0, 8'ha5);
    rd(ACC_IO_READ, 30);
    chk("port b dir", 8'(m[4]), port_b_dir);
    chk("port b out", 8'(m[5]), port_b_out);
    chk("port c dir", 8'(m[7] & MASK_PC), port_c_dir);
    chk("port c out", 8'(m[8] & MASK_PC), port_c_out);
    chk("port d out", 8'(m[11]), port_d_out);
    chk("eeprom control", 8'(m[31] & MASK_EE), ee_ctrl);
    pulse();
    foreach (fl[j])
    begin
      wr(ACC_IO_WRITE, fl[j], rnd());
      rd(ACC_IO_READ, fl[j]);
    end
    chk("t0 flags", 8'(m[21] & MASK_T0), t0_flags);
    chk("pin change flags", 8'(m[27] & MASK_PCH), pch_flags);
    wr(ACC_IO_WRITE, 22, 8'h00);
    // a set pulse and a clearing write in the same cycle: the set wins
    fork
      pulse();
      core.op(ACC_IO_WRITE, 8'h15, 3'h0, 8'hff);
    join
    rd(ACC_IO_READ, 21);
    pulse();
    bop(ACC_BIT_SET, 23, 1);
    chk("t2 flags", 8'(m[23] & MASK_T2), t2_flags);
    foreach (rw[j])
      for (int b = 0; b < 8; b++)
      begin
        bop(ACC_BIT_SET, (j == 2) ? 22 : rw[j], b);
        bop(ACC_BIT_TEST, (j == 2) ? 22 : rw[j], b);
        bop(ACC_BIT_CLR, (j == 2) ? 22 : rw[j], b);
        bop(ACC_BIT_TEST, (j == 2) ? 22 : rw[j], b);
      end
    bop(ACC_BIT_SET, 8'h25, 0);
    chk("port b out", 8'(m[5]), port_b_out);
    xop(ACC_DS_WRITE, 8'h80, 1'b1);
    xop(ACC_DS_READ, 8'hff, 1'b1);
    chk("ext read data", ext_rdata, acc_rdata);
    xop(ACC_IO_READ, 8'h60, 1'b0);
    chk("t1 flags", 8'(m[22] & MASK_T1), t1_flags);
    chk("port d dir", 8'(m[10]), port_d_dir);
    @(negedge core_clk);
    rst_n = 1'b0;
    foreach (m[i]) m[i] = 0;
    @(negedge core_clk);
    chk("port b dir", 8'h00, port_b_dir);
    rst_n = 1'b1;
    rd(ACC_IO_READ, 22);
    summarize();
  end
  // watchdog
  initial
  begin
    #400000;
    n_fail++;
    summarize();
  end
endmodule : tb_io_register_space_decoder
`default_nettype wire
